// ---- src/eeprom_read_map.svh ----
// Constants for the serial memory read, hold and command control block
// Behaviour
// - Read opcode then 24 address bits starts read
// - Data shifts out right after last address bit
// - Pointer advances per byte while clocking continues
// - Array pointer wraps from top to zero
// - Select high ends read, output stops
// - Identification read needs select bit set first
// - Identification pointer uses low eight bits only
// - Status opcode shifts out whole status byte
// - Status read served even during write cycle
// - Pause floats output and ignores data input
// - Power-up standby with write latch cleared
// - Completed write clears write enable latch
// - Write starts on select rise with exact count
// - Busy device ignores array commands, keeps programming
// - Unknown opcode ignored, output stays floating
// - Held in reset below trigger, standby above
// - Busy flag one during write, zero when ready
// - Identification select clears after read or write
// - Array uses low 17 address bits only
`ifndef EEPROM_READ_MAP_SVH
`define EEPROM_READ_MAP_SVH

`define OP_WRSR 8'h01
`define OP_WRITE 8'h02
`define OP_READ 8'h03
`define OP_WRDI 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_ENABLE 8'h06

`define CMD_BITS 12'h008
`define LAST_ADDR_BIT 12'h01F
`define WRSR_BITS 12'h010
`define WRITE_MIN_BITS 12'h028
`define WRITE_MAX_BITS 12'h820
`define BIT_SAT 12'hFFF
`define ARRAY_BITS 17
`define IDENT_BITS 8

`define SR_WPEN 7
`define SR_IDENT_PAGE_SELECT 6
`define SR_LIP 4
`define SR_BP1 3
`define SR_BP0 2
`define SR_WRITE_ENABLE_LATCH 1
`define SR_RDY 0
`define SR_WRITABLE 8'hDC

`define MCLK_MHZ 10
`define WRITE_TIME_US 5000
`define EMPTY_BYTE 8'hFF
`define PIN_RESET 4'hF

`endif

// ---- src/eeprom_read_pkg.sv ----
// Types shared by the serial memory control block
package eeprom_read_pkg;
  typedef enum logic [2:0] {
    ph_opcode, ph_addr, ph_read, ph_status, ph_wdata, ph_ignore
  } phase_t;

  typedef enum logic [2:0] {
    op_none, op_read, op_status, op_write_enable, op_wrdi, op_write, op_wrsr
  } op_t;
endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d.s1 = pin;
    d.s2 = q.s1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync = q.s2;
endmodule

// ---- src/byte_fifo.sv ----
// Small flip-flop FIFO with flush, valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != CW'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wr] = in_data;
        d.wr = (q.wr == PW'(D - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
        d.rd = (q.rd == PW'(D - 1)) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop) begin
        d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- src/spi_eeprom_read_hold_control.sv ----
// Serial memory target: command decode, array and status reads, pause, write start
`timescale 1ns/1ps
`include "eeprom_read_map.svh"
module spi_eeprom_read_hold_control
  import eeprom_read_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  output logic so_out,
  output logic so_oe,
  output logic mem_fetch,
  output logic [16:0] mem_addr,
  output logic mem_ident,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [7:0] mem_data,
  output logic wr_byte_valid,
  output logic [7:0] wr_byte,
  output logic wr_commit,
  output logic wr_status,
  output logic [16:0] wr_addr,
  output logic wr_ident,
  output logic [7:0] status_byte
);
  typedef struct packed {
    phase_t ph;
    op_t op;
    logic [11:0] bits;
    logic [7:0] in_sh;
    logic [23:0] addr;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic out_on;
    logic hold;
    logic sck_prev;
    logic cs_prev;
    logic fetch_on;
    logic ident_rd;
    logic [16:0] fetch;
    logic wpen;
    logic ident_page_select;
    logic lip;
    logic bp1;
    logic bp0;
    logic write_enable_latch;
    logic rdy;
    logic [7:0] wrsr_val;
    logic [16:0] wr_addr;
    logic wr_ident;
    logic wr_status;
    logic [19:0] timer;
    logic commit;
    logic [7:0] wr_byte;
    logic wr_byte_valid;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;

  logic [3:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic hold_n_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic push;
  logic [7:0] stat;

  // Pins are asynchronous to mclk; link clock must stay well below mclk/4
  pin_sync #(
    .W(4),
    .RST_VAL(`PIN_RESET)
  ) u_pins (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin({cs_n, hold_n, sck, si}),
    .sync(pins_s)
  );

  assign cs_s = pins_s[3];
  assign hold_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  // Prefetch ahead of the shifter so each byte is ready at its first falling edge
  byte_fifo #(
    .W(8),
    .D(8)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(cs_s),
    .in_valid(mem_valid && q.fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(mem_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign mem_ready = fifo_in_ready && q.fetch_on;
  assign push = mem_valid && mem_ready;

  always_comb begin
    stat = 8'h00;
    stat[`SR_WPEN] = q.wpen;
    stat[`SR_IDENT_PAGE_SELECT] = q.ident_page_select;
    stat[`SR_LIP] = q.lip;
    stat[`SR_BP1] = q.bp1;
    stat[`SR_BP0] = q.bp0;
    stat[`SR_WRITE_ENABLE_LATCH] = q.write_enable_latch;
    stat[`SR_RDY] = q.rdy;
  end

  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    logic [23:0] addr_in;
    logic [7:0] wv;
    rise = 1'b0;
    fall = 1'b0;
    byte_in = 8'h00;
    addr_in = 24'h000000;
    wv = 8'h00;
    d = q;
    fifo_pop = 1'b0;
    d.commit = 1'b0;
    d.wr_byte_valid = 1'b0;
    d.sck_prev = sck_s;
    d.cs_prev = cs_s;
    // Edges are not seen while paused
    rise = sck_s && !q.sck_prev && !q.hold;
    fall = !sck_s && q.sck_prev && !q.hold;
    byte_in = {q.in_sh[6:0], si_s};
    addr_in = {q.addr[22:0], si_s};

    // Self-timed write; commands other than status are locked out meanwhile
    if (q.rdy) begin
      d.timer = q.timer - 1'b1;
      if (q.timer == 20'h00001) begin
        d.rdy = 1'b0;
        d.write_enable_latch = 1'b0;
        if (q.wr_status) begin
          wv = q.wrsr_val & `SR_WRITABLE;
          d.wpen = wv[`SR_WPEN];
          d.bp1 = wv[`SR_BP1];
          d.bp0 = wv[`SR_BP0];
          // Setting both page bits at once leaves both unchanged
          if (!(wv[`SR_IDENT_PAGE_SELECT] && wv[`SR_LIP])) begin
            d.ident_page_select = wv[`SR_IDENT_PAGE_SELECT];
            d.lip = q.lip | wv[`SR_LIP];
          end
        end else begin
          d.ident_page_select = 1'b0;
        end
      end
    end

    if (push) begin
      if (q.ident_rd) begin
        d.fetch = {q.fetch[16:8], q.fetch[7:0] + 8'h01};
      end else begin
        d.fetch = q.fetch + 17'h00001;
      end
    end

    if (cs_s) begin
      if (!q.cs_prev) begin
        unique case (q.op)
          op_write_enable: begin
            if (q.bits == `CMD_BITS) d.write_enable_latch = 1'b1;
          end
          op_wrdi: begin
            if (q.bits == `CMD_BITS) d.write_enable_latch = 1'b0;
          end
          op_write: begin
            if (q.write_enable_latch && q.bits >= `WRITE_MIN_BITS && q.bits <= `WRITE_MAX_BITS
                && q.bits[2:0] == 3'h0) begin
              d.rdy = 1'b1;
              d.timer = 20'(WRITE_CYCLES);
              d.wr_status = 1'b0;
              d.commit = 1'b1;
            end
          end
          op_wrsr: begin
            if (q.write_enable_latch && q.bits == `WRSR_BITS) begin
              d.rdy = 1'b1;
              d.timer = 20'(WRITE_CYCLES);
              d.wr_status = 1'b1;
              d.commit = 1'b1;
            end
          end
          op_read: begin
            if (q.ph == ph_read) d.ident_page_select = 1'b0;
          end
          op_none, op_status: begin
          end
        endcase
      end
      // Deselected: transaction state dropped, output floated
      d.ph = ph_opcode;
      d.op = op_none;
      d.bits = 12'h000;
      d.out_on = 1'b0;
      d.out_cnt = 3'h0;
      d.fetch_on = 1'b0;
      d.hold = 1'b0;
    end else begin
      if (!q.hold && !hold_n_s && !sck_s) d.hold = 1'b1;
      if (q.hold && hold_n_s && !sck_s) d.hold = 1'b0;

      if (rise) begin
        d.in_sh = byte_in;
        if (q.bits != `BIT_SAT) d.bits = q.bits + 12'h001;
        unique case (q.ph)
          ph_opcode: begin
            if (q.bits == `CMD_BITS - 12'h001) begin
              d.ph = ph_ignore;
              d.op = op_none;
              if (!q.rdy || byte_in == `OP_READ_STATUS) begin
                unique case (byte_in)
                  `OP_READ: begin
                    d.op = op_read;
                    d.ph = ph_addr;
                  end
                  `OP_READ_STATUS: begin
                    d.op = op_status;
                    d.ph = ph_status;
                    d.out_cnt = 3'h0;
                  end
                  `OP_WRITE_ENABLE: d.op = op_write_enable;
                  `OP_WRDI: d.op = op_wrdi;
                  `OP_WRITE: begin
                    d.op = op_write;
                    d.ph = ph_addr;
                  end
                  `OP_WRSR: begin
                    d.op = op_wrsr;
                    d.ph = ph_wdata;
                  end
                  default: d.op = op_none;
                endcase
              end
            end
          end
          ph_addr: begin
            d.addr = addr_in;
            if (q.bits == `LAST_ADDR_BIT) begin
              if (q.op == op_read) begin
                d.ph = ph_read;
                d.fetch_on = 1'b1;
                d.ident_rd = q.ident_page_select;
                d.fetch = addr_in[16:0];
                d.out_cnt = 3'h0;
              end else begin
                d.ph = ph_wdata;
                d.wr_ident = q.ident_page_select;
                d.wr_addr = addr_in[16:0];
              end
            end
          end
          ph_wdata: begin
            if (q.bits[2:0] == 3'h7) begin
              if (q.op == op_write) begin
                d.wr_byte = byte_in;
                d.wr_byte_valid = 1'b1;
              end else begin
                d.wrsr_val = byte_in;
              end
            end
          end
          ph_read, ph_status, ph_ignore: begin
          end
        endcase
      end

      // Output changes after falling edges only
      if (fall && (q.ph == ph_read || q.ph == ph_status)) begin
        d.out_on = 1'b1;
        d.out_cnt = q.out_cnt + 3'h1;
        if (q.out_cnt == 3'h0) begin
          if (q.ph == ph_read) begin
            d.out_sh = fifo_out_valid ? fifo_out_data : `EMPTY_BYTE;
            fifo_pop = fifo_out_valid;
          end else begin
            d.out_sh = stat;
          end
        end else begin
          d.out_sh = {q.out_sh[6:0], 1'b0};
        end
      end
    end
  end

  // Power-on reset stands in for the supply monitor
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ph <= ph_opcode;
      q.op <= op_none;
      q.sck_prev <= 1'b1;
      q.cs_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign so_out = q.out_sh[7];
  assign so_oe = q.out_on && !q.hold;
  assign mem_fetch = q.fetch_on;
  assign mem_addr = q.fetch;
  assign mem_ident = q.ident_rd;
  assign wr_byte_valid = q.wr_byte_valid;
  assign wr_byte = q.wr_byte;
  assign wr_commit = q.commit;
  assign wr_status = q.wr_status;
  assign wr_addr = q.wr_addr;
  assign wr_ident = q.wr_ident;
  assign status_byte = stat;
endmodule

// ---- sim/eeprom_ctl_sva.sv ----
// Port-level assertions for the serial memory control block
`timescale 1ns/1ps
module eeprom_ctl_sva #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic so_oe,
  input wire logic mem_fetch,
  input wire logic [16:0] mem_addr,
  input wire logic mem_ident,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic wr_commit,
  input wire logic [7:0] status_byte
);
  logic [15:0] busy_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Length of the current busy stretch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      busy_q <= 16'h0000;
    else
      busy_q <= status_byte[0] ? busy_q + 16'h0001 : 16'h0000;
  end
  AST_CS_OFF:
    assert property (cs_n [*6] |-> !so_oe) else $error("output driven while deselected");
  AST_HOLD_OFF:
    assert property ((!hold_n && !sck) [*8] |-> !so_oe) else $error("output driven in pause");
  AST_COMMIT_ONE:
    assert property (wr_commit |-> cs_n ##1 !wr_commit) else $error("bad write start pulse");
  AST_COMMIT_BUSY:
    assert property (wr_commit |-> ##[1:3] status_byte[0]) else $error("busy not raised");
  AST_BUSY_LEN:
    assert property ($fell(status_byte[0]) |-> busy_q >= WRITE_CYCLES - 1
      && busy_q <= WRITE_CYCLES + 1) else $error("busy length wrong");
  AST_WEL_CLR:
    assert property ($fell(status_byte[0]) |-> !status_byte[1]) else $error("latch kept");
  AST_BUSY_NOREAD:
    assert property (status_byte[0] |-> !mem_fetch) else $error("fetch while busy");
  AST_ADDR_STEP:
    assert property (mem_valid && mem_ready && !mem_ident && !cs_n
      |=> mem_addr == $past(mem_addr) + 17'h00001) else $error("array pointer step");
  AST_IDENT_STEP:
    assert property (mem_valid && mem_ready && mem_ident && !cs_n
      |=> mem_addr[7:0] == $past(mem_addr[7:0]) + 8'h01) else $error("page pointer step");
endmodule

bind spi_eeprom_read_hold_control eeprom_ctl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
  .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .hold_n(hold_n),
  .so_oe(so_oe), .mem_fetch(mem_fetch), .mem_addr(mem_addr), .mem_ident(mem_ident),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .wr_commit(wr_commit),
  .status_byte(status_byte));

// ---- sim/spi_host_model.sv ----
// Host side of the serial link: select, clock, data and pause
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk,
  input wire logic so_out,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic oe_seen;
  // Clock idle level between frames: 0 for mode 0, 1 for mode 3
  logic cpol;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
    cpol = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic frame(input logic on);
    // Settle the idle clock level first so no edge coincides with select
    sck <= cpol;
    tick(2);
    cs_n <= !on;
    // Released data line must not look driven
    if (!on)
      si <= !si;
    tick(6);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      tick(4);
      // An undriven output line must not pass for the expected bit
      rx[i] = so_oe ? so_out : !so_out;
      oe_seen = oe_seen | so_oe;
      sck <= 1'b1;
      tick(4);
    end
  endtask
  task automatic pause(output logic oe);
    sck <= 1'b0;
    tick(4);
    hold_n <= 1'b0;
    tick(10);
    si <= !si;
    oe = so_oe;
    tick(4);
    hold_n <= 1'b1;
    tick(4);
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the serial memory control block
`timescale 1ns/1ps
module tb_top;
  import eeprom_read_pkg::*;
  logic mclk, reset_n, cs_n, sck, si, hold_n, so_out, so_oe;
  logic mem_fetch, mem_ident, mem_valid, mem_ready;
  logic [16:0] mem_addr;
  logic [7:0] mem_data, status_byte, r;
  logic wr_byte_valid, wr_status, wr_ident;
  logic [7:0] wr_byte;
  logic [16:0] wr_addr;
  logic [7:0] bad [3] = '{8'h00, 8'hAA, 8'hFF};
  int n_tests, miscompares, seed, n_wr;
  spi_eeprom_read_hold_control #(.WRITE_CYCLES(800)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe), .mem_fetch(mem_fetch), .mem_addr(mem_addr),
    .mem_ident(mem_ident), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_data(mem_data), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .wr_commit(),
    .wr_status(wr_status), .wr_addr(wr_addr), .wr_ident(wr_ident), .status_byte(status_byte));
  spi_host_model i_host (.mclk(mclk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));
  function automatic logic [7:0] mem_val(input logic [16:0] a, input logic id);
    return id ? ~a[7:0] : a[7:0] ^ {a[16], a[14:8]};
  endfunction
  // Memory answers every other cycle so data always matches the address
  always @(posedge mclk) begin
    mem_valid <= mem_fetch && !mem_valid;
    mem_data <= mem_val(mem_addr, mem_ident);
    if (wr_byte_valid)
      n_wr <= n_wr + 1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input int nb, input logic [7:0] d);
    i_host.oe_seen = 1'b0;
    i_host.frame(1'b1);
    i_host.xfer(op, r);
    repeat (nb) i_host.xfer(d, r);
    i_host.frame(1'b0);
  endtask
  task automatic rd(input logic [23:0] a, input int n, input int hp, input logic id);
    logic oe;
    logic [16:0] p;
    p = a[16:0];
    cmd(8'h03, 0, 8'h00);
    i_host.frame(1'b1);
    i_host.xfer(8'h03, r);
    for (int i = 2; i >= 0; i--) i_host.xfer(a[i*8 +: 8], r);
    for (int i = 0; i < n; i++) begin
      if (i == hp) begin
        i_host.pause(oe);
        chk("pause oe", 8'h00, {7'h00, oe});
      end
      i_host.xfer(8'h00, r);
      chk("read", mem_val(p, id), r);
      p = p + 17'h00001;
    end
    i_host.frame(1'b0);
    chk("end oe", 8'h00, {7'h00, so_oe});
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (status_byte[0] !== 1'b0 && k < 1000) begin
      @(posedge mclk);
      k++;
    end
    if (k == 1000) begin
      miscompares++;
      summarize();
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    seed = 88834;
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cmd(8'h05, 1, 8'h00);
    chk("status", 8'h00, r);
    for (int t = 0; t < 4; t++) rd(24'($random(seed)), 3, 9, 1'b0);
    rd(24'hFE_FFFF, 3, 1, 1'b0);
    foreach (bad[i]) begin
      cmd(bad[i], 2, 8'h00);
      chk("bad op oe", 8'h00, {7'h00, i_host.oe_seen});
    end
    i_host.cpol = 1'b1;
    cmd(8'h05, 1, 8'h00);
    chk("status mode 3", 8'h00, r);
    rd(24'h01_FFFE, 3, 2, 1'b0);
    i_host.cpol = 1'b0;
    cmd(8'h06, 0, 8'h00);
    cmd(8'h01, 1, 8'h40);
    wait_idle();
    chk("status write kind", 8'h01, {7'h00, wr_status});
    cmd(8'h05, 1, 8'h00);
    chk("page select", 8'h40, r);
    rd(24'h12_34FD, 2, 9, 1'b1);
    cmd(8'h05, 1, 8'h00);
    chk("page select cleared", 8'h00, r);
    cmd(8'h06, 0, 8'h00);
    cmd(8'h02, 3, 8'h00);
    chk("short write", 8'h00, {7'h00, status_byte[0]});
    cmd(8'h02, 4, 8'h5A);
    chk("write byte", 8'h5A, wr_byte);
    chk("write addr", 8'h5A, wr_addr[15:8]);
    chk("write flags", 8'h00, {5'h00, wr_addr[16], wr_status, wr_ident});
    chk("write strobes", 8'h01, 8'(n_wr));
    cmd(8'h03, 4, 8'h00);
    chk("read while busy", 8'h00, {7'h00, i_host.oe_seen});
    cmd(8'h05, 1, 8'h00);
    chk("busy status", 8'h03, r);
    wait_idle();
    chk("idle status", 8'h00, status_byte);
    cmd(8'h06, 0, 8'h00);
    chk("latch set", 8'h02, status_byte);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("after reset", 8'h00, status_byte);
    summarize();
  end
endmodule
